// *** rtl/ivm_defines.vh ***
// Constants of the low interrupt vector map: offsets, fields, vectors
`ifndef IVM_DEFINES_VH
`define IVM_DEFINES_VH

// ============================================================
// Register offsets (byte addresses)
`define IVM_OFS_TMR_EN    8'h00
`define IVM_OFS_PER_EN    8'h04
`define IVM_OFS_PRIO0     8'h08
`define IVM_OFS_PRIO1     8'h0c
`define IVM_OFS_SOFT      8'h10
`define IVM_OFS_PEND      8'h14
`define IVM_OFS_ACTIVE    8'h18

// ============================================================
// Reset values
`define IVM_RST_TMR_EN    15'h0000
`define IVM_RST_PER_EN    10'h000
`define IVM_RST_PRIO0     10'h000
`define IVM_RST_PRIO1     14'h0000
`define IVM_RST_SOFT      4'h0

// ============================================================
// Peripheral enable register fields
`define IVM_PER_CLK_LSB   0
`define IVM_PER_SUP_LSB   3
`define IVM_PER_XBAR_LSB  5
`define IVM_PER_ECF_BIT   9

// Priority field positions, two bits each
`define IVM_P0_RX_LSB     0
`define IVM_P0_TX_LSB     2
`define IVM_P0_TRB_LSB    4
`define IVM_P0_BKPT_LSB   6
`define IVM_P0_STEP_LSB   8
`define IVM_P1_TMR1_LSB   0
`define IVM_P1_TMR2_LSB   2
`define IVM_P1_TMR3_LSB   4
`define IVM_P1_CLK_LSB    6
`define IVM_P1_SUP_LSB    8
`define IVM_P1_XBAR_LSB   10
`define IVM_P1_BERR_LSB   12

// ============================================================
// Vector numbers
`define IVM_VEC_TMR1      5'h1b
`define IVM_VEC_TMR2      5'h1a
`define IVM_VEC_TMR3      5'h19
`define IVM_VEC_CLK       5'h14
`define IVM_VEC_SUP       5'h13
`define IVM_VEC_XBAR      5'h12
`define IVM_VEC_SOFT0     5'h11
`define IVM_VEC_SOFT1     5'h10
`define IVM_VEC_SOFT2     5'h0f
`define IVM_VEC_BERR      5'h0b
`define IVM_VEC_DBG_RX    5'h0a
`define IVM_VEC_DBG_TX    5'h09
`define IVM_VEC_TRB       5'h08
`define IVM_VEC_BKPT      5'h07
`define IVM_VEC_STEP      5'h06
`define IVM_VEC_MISAL     5'h05
`define IVM_VEC_STKOVF    5'h04
`define IVM_VEC_SOFT3     5'h03
`define IVM_VEC_BADOP     5'h02

// Fixed priority levels
`define IVM_LVL_0         2'h0
`define IVM_LVL_1         2'h1
`define IVM_LVL_2         2'h2
`define IVM_LVL_3         2'h3

`endif

// *** rtl/ivm_src_merge.v ***
// Merges status flags, each gated by its own enable, into one request
`timescale 1ns/1ps

module ivm_src_merge #(
  parameter N = 5
) (
  input  wire [N-1:0] flags,
  input  wire [N-1:0] en,
  output wire         req
);

  // ============================================================
  // Merge
  assign req = |(flags & en);

endmodule // ivm_src_merge

// *** rtl/ivm_prio_pick.v ***
// Picks the highest-level pending vector and holds it in flip-flops
`timescale 1ns/1ps

module ivm_prio_pick #(
  parameter NVEC = 28,
  parameter VW   = 5
) (
  input  wire              clk,
  input  wire              rstn,
  input  wire [NVEC-1:0]   req,
  input  wire [2*NVEC-1:0] lvl,
  output reg               irq_req_q,
  output reg  [VW-1:0]     irq_vec_q,
  output reg  [1:0]        irq_lvl_q
);

  integer         i;
  reg             found_d;
  reg  [VW-1:0]   vec_d;
  reg  [1:0]      lvl_d;

  // ============================================================
  // Search, lowest vector wins a tie
  always @* begin
    found_d = 1'b0;
    vec_d   = {VW{1'b0}};
    lvl_d   = 2'h0;
    for (i = NVEC - 1; i >= 0; i = i - 1) begin
      if (req[i] && (!found_d || lvl[2*i +: 2] >= lvl_d)) begin
        found_d = 1'b1;
        vec_d   = i[VW-1:0];
        lvl_d   = lvl[2*i +: 2];
      end
    end
  end

  // ============================================================
  // Output flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= {VW{1'b0}};
      irq_lvl_q <= 2'h0;
    end else begin
      irq_req_q <= found_d;
      irq_vec_q <= vec_d;
      irq_lvl_q <= lvl_d;
    end
  end

endmodule // ivm_prio_pick

// *** rtl/ivm_vector_map.v ***
// Low interrupt vector map: source merge, priority and vector output
//
// Operation
// - Timer channel one requests vector 27, address 0x36, level 0-2.
// - Timer channel three requests vector 25, address 0x32, level 0-2.
// - Clock generator lock or reference loss requests vector 20, level 1-3.
// - Supply supervisor low voltage requests vector 19, level 1-3.
// - Crossbar merges four enabled flags onto vector 18, level 1-3.
// - Software interrupt zero uses vector 17, fixed level 0, no enable.
// - Software interrupt one uses vector 16, fixed level 1, no enable.
// - Software interrupt two uses vector 15, fixed level 2, no enable.
// - Bus error requests vector 11, level 0-2, gated by capture enable.
// - Debug receive full requests vector 10, enabled by its priority field.
// - Debug transmit, trace, breakpoint, step use vectors 9 to 6.
// - Misaligned access raises vector 5 at fixed level 3, unmaskable.
// - Stack overflow raises vector 4 at fixed level 3, unmaskable.
// - Software interrupt three uses vector 3 at fixed level 3.
// - Illegal instruction raises vector 2 at fixed level 3, unmaskable.
// - Vectors 1 and 0 are reset overlay slots, never requested here.
// - Reserved vectors 24-21 and 14-12 are never requested.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ivm_defines.vh"

module ivm_vector_map #(
  parameter NVEC = 28,
  parameter VW   = 5,
  parameter AW   = 8
) (
  input  wire          clk,
  input  wire          rstn,
  // Register port
  input  wire [AW-1:0] reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  // Timer flags per channel: compare, overflow, edge, compare 1, 2
  input  wire [4:0]    timer_ch1_flags,
  input  wire [4:0]    timer_ch2_flags,
  input  wire [4:0]    timer_ch3_flags,
  // Clock generator: lock 1 loss, lock 0 loss, reference loss
  input  wire          lock1_status,
  input  wire          lock0_status,
  input  wire          ref_loss_flag,
  // Supply supervisor
  input  wire          io_low_volt_status,
  input  wire          core_low_volt_status,
  // Crossbar status flags of two control registers
  input  wire [3:0]    xbar_status,
  // Core events
  input  wire          bus_error,
  input  wire          dbg_rx_full,
  input  wire          dbg_tx_empty,
  input  wire          dbg_trace_buffer,
  input  wire          dbg_breakpoint,
  input  wire          dbg_step_counter,
  input  wire          misaligned_access,
  input  wire          stack_overflow,
  input  wire          bad_opcode_trap,
  // Core side
  input  wire          irq_ack,
  output wire          irq_req,
  output wire [VW-1:0] irq_vec,
  output wire [1:0]    irq_level,
  output wire [VW:0]   irq_addr
);

  // ============================================================
  // Field decoding helpers
  function field_on;
    input [1:0] f;
    begin
      field_on = |f;
    end
  endfunction

  // Field code 1-3 maps to level 0-2 or to level 1-3
  function [1:0] field_lvl;
    input [1:0] f;
    input       upper;
    begin
      if (upper)
        field_lvl = f;
      else
        field_lvl = f - 2'h1;
    end
  endfunction

  // ============================================================
  // Registers
  reg  [14:0]       tmr_en_q;
  reg  [9:0]        per_en_q;
  reg  [9:0]        prio0_q;
  reg  [13:0]       prio1_q;
  reg  [3:0]        soft_q;
  reg  [3:0]        soft_d;
  reg  [31:0]       rdata_d;

  wire [NVEC-1:0]   req;
  wire [2*NVEC-1:0] lvl;
  wire [2:0]        tmr_req;
  wire [14:0]       tmr_flags;
  wire              clk_req;
  wire              sup_req;
  wire              xbar_req;
  wire              pick_req;
  wire [VW-1:0]     pick_vec;
  wire [1:0]        pick_lvl;
  wire [3:0]        soft_clr;

  assign tmr_flags = {timer_ch3_flags, timer_ch2_flags, timer_ch1_flags};

  // ============================================================
  // Timer channel merges
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tmr
      ivm_src_merge #(
        .N     (5)
      ) u_merge (
        .flags (tmr_flags[5*g +: 5]),
        .en    (tmr_en_q[5*g +: 5]),
        .req   (tmr_req[g])
      );
    end
  endgenerate

  // ============================================================
  // Peripheral merges
  ivm_src_merge #(
    .N     (3)
  ) u_clk_merge (
    .flags ({ref_loss_flag, lock0_status, lock1_status}),
    .en    (per_en_q[`IVM_PER_CLK_LSB +: 3]),
    .req   (clk_req)
  );

  ivm_src_merge #(
    .N     (2)
  ) u_sup_merge (
    .flags ({core_low_volt_status, io_low_volt_status}),
    .en    (per_en_q[`IVM_PER_SUP_LSB +: 2]),
    .req   (sup_req)
  );

  ivm_src_merge #(
    .N     (4)
  ) u_xbar_merge (
    .flags (xbar_status),
    .en    (per_en_q[`IVM_PER_XBAR_LSB +: 4]),
    .req   (xbar_req)
  );

  // ============================================================
  // Request vector, one bit per vector number
  assign req[`IVM_VEC_TMR1] = tmr_req[0]
    & field_on(prio1_q[`IVM_P1_TMR1_LSB +: 2]);
  assign req[`IVM_VEC_TMR2] = tmr_req[1]
    & field_on(prio1_q[`IVM_P1_TMR2_LSB +: 2]);
  assign req[`IVM_VEC_TMR3] = tmr_req[2]
    & field_on(prio1_q[`IVM_P1_TMR3_LSB +: 2]);
  assign req[24:21] = 4'h0;
  assign req[`IVM_VEC_CLK] = clk_req
    & field_on(prio1_q[`IVM_P1_CLK_LSB +: 2]);
  assign req[`IVM_VEC_SUP] = sup_req
    & field_on(prio1_q[`IVM_P1_SUP_LSB +: 2]);
  assign req[`IVM_VEC_XBAR] = xbar_req
    & field_on(prio1_q[`IVM_P1_XBAR_LSB +: 2]);
  assign req[`IVM_VEC_SOFT0] = soft_q[0];
  assign req[`IVM_VEC_SOFT1] = soft_q[1];
  assign req[`IVM_VEC_SOFT2] = soft_q[2];
  assign req[14:12] = 3'h0;
  assign req[`IVM_VEC_BERR] = bus_error & per_en_q[`IVM_PER_ECF_BIT]
    & field_on(prio1_q[`IVM_P1_BERR_LSB +: 2]);
  assign req[`IVM_VEC_DBG_RX] = dbg_rx_full
    & field_on(prio0_q[`IVM_P0_RX_LSB +: 2]);
  assign req[`IVM_VEC_DBG_TX] = dbg_tx_empty
    & field_on(prio0_q[`IVM_P0_TX_LSB +: 2]);
  assign req[`IVM_VEC_TRB] = dbg_trace_buffer
    & field_on(prio0_q[`IVM_P0_TRB_LSB +: 2]);
  assign req[`IVM_VEC_BKPT] = dbg_breakpoint
    & field_on(prio0_q[`IVM_P0_BKPT_LSB +: 2]);
  assign req[`IVM_VEC_STEP] = dbg_step_counter
    & field_on(prio0_q[`IVM_P0_STEP_LSB +: 2]);
  assign req[`IVM_VEC_MISAL] = misaligned_access;
  assign req[`IVM_VEC_STKOVF] = stack_overflow;
  assign req[`IVM_VEC_SOFT3] = soft_q[3];
  assign req[`IVM_VEC_BADOP] = bad_opcode_trap;
  assign req[1:0] = 2'h0;

  // ============================================================
  // Level per vector
  assign lvl[2*`IVM_VEC_TMR1 +: 2] =
    field_lvl(prio1_q[`IVM_P1_TMR1_LSB +: 2], 1'b0);
  assign lvl[2*`IVM_VEC_TMR2 +: 2] =
    field_lvl(prio1_q[`IVM_P1_TMR2_LSB +: 2], 1'b0);
  assign lvl[2*`IVM_VEC_TMR3 +: 2] =
    field_lvl(prio1_q[`IVM_P1_TMR3_LSB +: 2], 1'b0);
  assign lvl[2*21 +: 8] = 8'h00;
  assign lvl[2*`IVM_VEC_CLK +: 2] =
    field_lvl(prio1_q[`IVM_P1_CLK_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_SUP +: 2] =
    field_lvl(prio1_q[`IVM_P1_SUP_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_XBAR +: 2] =
    field_lvl(prio1_q[`IVM_P1_XBAR_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_SOFT0 +: 2] = `IVM_LVL_0;
  assign lvl[2*`IVM_VEC_SOFT1 +: 2] = `IVM_LVL_1;
  assign lvl[2*`IVM_VEC_SOFT2 +: 2] = `IVM_LVL_2;
  assign lvl[2*12 +: 6] = 6'h00;
  assign lvl[2*`IVM_VEC_BERR +: 2] =
    field_lvl(prio1_q[`IVM_P1_BERR_LSB +: 2], 1'b0);
  assign lvl[2*`IVM_VEC_DBG_RX +: 2] =
    field_lvl(prio0_q[`IVM_P0_RX_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_DBG_TX +: 2] =
    field_lvl(prio0_q[`IVM_P0_TX_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_TRB +: 2] =
    field_lvl(prio0_q[`IVM_P0_TRB_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_BKPT +: 2] =
    field_lvl(prio0_q[`IVM_P0_BKPT_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_STEP +: 2] =
    field_lvl(prio0_q[`IVM_P0_STEP_LSB +: 2], 1'b1);
  assign lvl[2*`IVM_VEC_MISAL +: 2] = `IVM_LVL_3;
  assign lvl[2*`IVM_VEC_STKOVF +: 2] = `IVM_LVL_3;
  assign lvl[2*`IVM_VEC_SOFT3 +: 2] = `IVM_LVL_3;
  assign lvl[2*`IVM_VEC_BADOP +: 2] = `IVM_LVL_3;
  assign lvl[1:0] = 2'h0;
  assign lvl[3:2] = 2'h0;

  // ============================================================
  // Priority pick
  ivm_prio_pick #(
    .NVEC      (NVEC),
    .VW        (VW)
  ) u_pick (
    .clk       (clk),
    .rstn      (rstn),
    .req       (req),
    .lvl       (lvl),
    .irq_req_q (pick_req),
    .irq_vec_q (pick_vec),
    .irq_lvl_q (pick_lvl)
  );

  assign irq_req   = pick_req;
  assign irq_vec   = pick_vec;
  assign irq_level = pick_lvl;
  assign irq_addr  = {pick_vec, 1'b0};

  // ============================================================
  // Software interrupts: set by write, cleared by acknowledge
  assign soft_clr[0] = irq_ack & pick_req & (pick_vec == `IVM_VEC_SOFT0);
  assign soft_clr[1] = irq_ack & pick_req & (pick_vec == `IVM_VEC_SOFT1);
  assign soft_clr[2] = irq_ack & pick_req & (pick_vec == `IVM_VEC_SOFT2);
  assign soft_clr[3] = irq_ack & pick_req & (pick_vec == `IVM_VEC_SOFT3);

  always @* begin
    soft_d = soft_q & ~soft_clr;
    if (reg_wr && reg_addr == `IVM_OFS_SOFT) begin
      soft_d = soft_d | reg_wdata[3:0];
    end
  end

  // ============================================================
  // Register writes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_en_q <= `IVM_RST_TMR_EN;
      per_en_q <= `IVM_RST_PER_EN;
      prio0_q  <= `IVM_RST_PRIO0;
      prio1_q  <= `IVM_RST_PRIO1;
      soft_q   <= `IVM_RST_SOFT;
    end else begin
      soft_q <= soft_d;
      if (reg_wr) begin
        case (reg_addr)
          `IVM_OFS_TMR_EN: tmr_en_q <= reg_wdata[14:0];
          `IVM_OFS_PER_EN: per_en_q <= reg_wdata[9:0];
          `IVM_OFS_PRIO0:  prio0_q  <= reg_wdata[9:0];
          `IVM_OFS_PRIO1:  prio1_q  <= reg_wdata[13:0];
          default: ;
        endcase
      end
    end
  end

  // ============================================================
  // Register reads, data one cycle after the strobe
  always @* begin
    case (reg_addr)
      `IVM_OFS_TMR_EN: rdata_d = {17'h00000, tmr_en_q};
      `IVM_OFS_PER_EN: rdata_d = {22'h000000, per_en_q};
      `IVM_OFS_PRIO0:  rdata_d = {22'h000000, prio0_q};
      `IVM_OFS_PRIO1:  rdata_d = {18'h00000, prio1_q};
      `IVM_OFS_SOFT:   rdata_d = {28'h0000000, soft_q};
      `IVM_OFS_PEND:   rdata_d = {{(32-NVEC){1'b0}}, req};
      `IVM_OFS_ACTIVE: rdata_d = {{(23-VW){1'b0}}, pick_req, 6'h00,
                                  pick_lvl, pick_vec};
      default:         rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // ivm_vector_map

// *** verif/ivm_vector_map_chk.sv ***
// Checker for the low interrupt vector map outputs
`timescale 1ns/1ps

module ivm_vector_map_chk #(
  parameter VW = 5
) (
  input logic          clk,
  input logic          rstn,
  input logic          reg_rd,
  input logic [31:0]   reg_rdata,
  input logic          misaligned_access,
  input logic          stack_overflow,
  input logic          bad_opcode_trap,
  input logic          irq_req,
  input logic [VW-1:0] irq_vec,
  input logic [1:0]    irq_level,
  input logic [VW:0]   irq_addr
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  addr_twice_a: assert property (
    irq_addr == {irq_vec, 1'b0}) else $error("address not twice vector");
  no_reserved_a: assert property (
    irq_req |-> !(irq_vec inside {5'h18, 5'h17, 5'h16, 5'h15, 5'h0e,
      5'h0d, 5'h0c, 5'h01, 5'h00})) else $error("reserved vector shown");
  misal_fix_a: assert property (
    misaligned_access |=> irq_req && irq_level == 2'h3 && irq_vec <= 5'h05)
    else $error("misaligned access not at level 3");
  stk_fix_a: assert property (
    stack_overflow |=> irq_req && irq_level == 2'h3 && irq_vec <= 5'h04)
    else $error("stack overflow not at level 3");
  badop_fix_a: assert property (
    bad_opcode_trap |=> irq_req && irq_level == 2'h3 && irq_vec == 5'h02)
    else $error("illegal instruction not vector 2");
  soft_lvl_a: assert property (
    irq_req && irq_vec inside {5'h11, 5'h10, 5'h0f, 5'h03} |->
    irq_level == ((irq_vec == 5'h03) ? 2'h3 : 2'(5'h11 - irq_vec)))
    else $error("soft interrupt level wrong");
  low_band_a: assert property (
    irq_req && irq_vec inside {5'h1b, 5'h1a, 5'h19, 5'h0b} |->
    irq_level != 2'h3) else $error("level above 2 on low band vector");
  high_band_a: assert property (
    irq_req && irq_vec inside {5'h14, 5'h13, 5'h12, 5'h0a, 5'h09, 5'h08,
      5'h07, 5'h06} |-> irq_level != 2'h0) else $error("level 0 on band 1-3");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");

  cover property (irq_req && irq_vec == 5'h11);
  cover property (irq_req && irq_vec == 5'h1b && irq_level == 2'h2);
  cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule // ivm_vector_map_chk

bind ivm_vector_map ivm_vector_map_chk #(.VW(VW)) u_chk (
  .clk(clk), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .misaligned_access(misaligned_access), .stack_overflow(stack_overflow),
  .bad_opcode_trap(bad_opcode_trap), .irq_req(irq_req),
  .irq_vec(irq_vec), .irq_level(irq_level), .irq_addr(irq_addr));

// *** verif/ivm_core_model.sv ***
// Core model that acknowledges presented vectors, promptly or slowly
`timescale 1ns/1ps

module ivm_core_model (
  input  logic       clk,
  input  logic       rstn,
  input  logic       irq_req,
  input  logic       slow,
  output logic       irq_ack
);
  logic [2:0] wait_q;
  logic [1:0] hold_q;

  // ==========================================================
  // Acknowledge one pulse, then hold off while the request drains
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack <= 1'b0;
      wait_q  <= 3'h0;
      hold_q  <= 2'h0;
    end else begin
      irq_ack <= 1'b0;
      if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (irq_req && wait_q == (slow ? 3'h3 : 3'h0)) begin
        irq_ack <= 1'b1;
        hold_q  <= 2'h3;
        wait_q  <= 3'h0;
      end else if (irq_req) begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule // ivm_core_model

// *** verif/ivm_vector_map_tb.sv ***
// Self-checking testbench of the low interrupt vector map
`timescale 1ns/1ps
`include "ivm_defines.vh"

module ivm_vector_map_tb;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [4:0] timer_ch1_flags = 5'h0, timer_ch2_flags = 5'h0;
  logic [4:0] timer_ch3_flags = 5'h0, fl;
  logic lock1_status = 1'b0, lock0_status = 1'b0, ref_loss_flag = 1'b0;
  logic io_low_volt_status = 1'b0, core_low_volt_status = 1'b0;
  logic [3:0] xbar_status = 4'h0;
  logic bus_error = 1'b0, dbg_rx_full = 1'b0, dbg_tx_empty = 1'b0;
  logic dbg_trace_buffer = 1'b0, dbg_breakpoint = 1'b0;
  logic dbg_step_counter = 1'b0, misaligned_access = 1'b0;
  logic stack_overflow = 1'b0, bad_opcode_trap = 1'b0;
  logic irq_ack, irq_req;
  logic [4:0] irq_vec;
  logic [1:0] irq_level;
  logic [5:0] irq_addr;
  logic [14:0] en;
  int mismatches = 0, num_checks = 0, n, ch;
  int vl[15] = '{27, 26, 25, 20, 19, 18, 11, 10, 9, 8, 7, 6, 5, 4, 2};
  logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                         8'h40};
  logic [31:0] msk[4] = '{32'h7fff, 32'h3ff, 32'h3ff, 32'h3fff};

  always #20 clk = ~clk;

  ivm_vector_map uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_ch1_flags(timer_ch1_flags),
    .timer_ch2_flags(timer_ch2_flags), .timer_ch3_flags(timer_ch3_flags),
    .lock1_status(lock1_status), .lock0_status(lock0_status),
    .ref_loss_flag(ref_loss_flag), .io_low_volt_status(io_low_volt_status),
    .core_low_volt_status(core_low_volt_status), .xbar_status(xbar_status),
    .bus_error(bus_error), .dbg_rx_full(dbg_rx_full),
    .dbg_tx_empty(dbg_tx_empty), .dbg_trace_buffer(dbg_trace_buffer),
    .dbg_breakpoint(dbg_breakpoint), .dbg_step_counter(dbg_step_counter),
    .misaligned_access(misaligned_access), .stack_overflow(stack_overflow),
    .bad_opcode_trap(bad_opcode_trap), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vec(irq_vec), .irq_level(irq_level),
    .irq_addr(irq_addr));

  ivm_core_model core (.clk(clk), .rstn(rstn), .irq_req(irq_req),
    .slow(slow), .irq_ack(irq_ack));

  // ==========================================================
  // Closing, comparison and bus tasks
  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_irq(input logic er, input int v, input logic [1:0] el);
    logic [13:0] got, exp;
    got = er ? {irq_req, irq_vec, irq_level, irq_addr} : {irq_req, 13'h0};
    exp = er ? {1'b1, v[4:0], el, v[4:0], 1'b0} : 14'h0;
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 dv = reg_rdata;
    @(posedge clk);
  endtask

  // ==========================================================
  // Source drive and expectations
  task automatic set_src(input int v, input logic on);
    case (v)
      27: timer_ch1_flags <= on ? 5'h1 << ($urandom % 5) : 5'h0;
      26: timer_ch2_flags <= on ? 5'h1 << ($urandom % 5) : 5'h0;
      25: timer_ch3_flags <= on ? 5'h1 << ($urandom % 5) : 5'h0;
      20: {lock1_status, lock0_status, ref_loss_flag} <=
            on ? 3'h1 << ($urandom % 3) : 3'h0;
      19: {io_low_volt_status, core_low_volt_status} <=
            on ? 2'h1 << ($urandom % 2) : 2'h0;
      18: xbar_status <= on ? 4'h1 << ($urandom % 4) : 4'h0;
      11: bus_error <= on;
      10: dbg_rx_full <= on;
      9: dbg_tx_empty <= on;
      8: dbg_trace_buffer <= on;
      7: dbg_breakpoint <= on;
      6: dbg_step_counter <= on;
      5: misaligned_access <= on;
      4: stack_overflow <= on;
      default: bad_opcode_trap <= on;
    endcase
  endtask

  function automatic logic [1:0] exp_lvl(input int v, input logic [1:0] c);
    if (v inside {5, 4, 2}) return 2'h3;
    if (v inside {27, 26, 25, 11}) return c - 2'h1;
    return c;
  endfunction

  task automatic one_vec(input int v);
    logic [1:0] c;
    c = $urandom % 4;
    wr(`IVM_OFS_PRIO0, {22'h0, {5{c}}});
    wr(`IVM_OFS_PRIO1, {18'h0, {7{c}}});
    set_src(v, 1'b1);
    @(posedge clk);
    #1 cmp_irq(v inside {5, 4, 2} || c != 2'h0, v, exp_lvl(v, c));
    @(posedge clk);
    set_src(v, 1'b0);
    repeat (2) @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h5843));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      cmp32(d, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      n = $urandom;
      wr(ofs[i], n);
      rd(ofs[i], d);
      cmp32(d, n & msk[i]);
    end
    for (int i = 5; i < 8; i++) begin
      wr(ofs[i], $urandom);
      rd(ofs[i], d);
      cmp32(d, 32'h0);
    end
    wr(`IVM_OFS_TMR_EN, 32'h7fff);
    wr(`IVM_OFS_PER_EN, 32'h3ff);
    repeat (3) begin
      for (int i = 0; i < 3; i++) one_vec(vl[i]);
      for (int i = 3; i < 7; i++) one_vec(vl[i]);
      for (int i = 7; i < 15; i++) one_vec(vl[i]);
    end
    wr(`IVM_OFS_PRIO1, 32'h1555);
    repeat (24) begin
      ch = $urandom % 3;
      en = $urandom;
      fl = $urandom;
      wr(`IVM_OFS_TMR_EN, {17'h0, en});
      if (ch == 0) timer_ch1_flags <= fl;
      else if (ch == 1) timer_ch2_flags <= fl;
      else timer_ch3_flags <= fl;
      @(posedge clk);
      #1 cmp_irq(|(fl & en[ch*5+:5]), 27 - ch, 2'h0);
      @(posedge clk);
      for (int i = 0; i < 3; i++) set_src(vl[i], 1'b0);
      repeat (2) @(posedge clk);
    end
    repeat (24) begin
      ch = $urandom % 3;
      en = $urandom;
      fl = $urandom;
      wr(`IVM_OFS_PER_EN, {22'h0, en[9:0]});
      if (ch == 0) {ref_loss_flag, lock0_status, lock1_status} <= fl[2:0];
      else if (ch == 1) {core_low_volt_status, io_low_volt_status} <= fl[1:0];
      else xbar_status <= fl[3:0];
      n = (ch == 0) ? |(fl[2:0] & en[2:0]) : (ch == 1) ?
        |(fl[1:0] & en[4:3]) : |(fl[3:0] & en[8:5]);
      @(posedge clk);
      #1 cmp_irq(n[0], 20 - ch, 2'h1);
      @(posedge clk);
      for (int i = 3; i < 6; i++) set_src(vl[i], 1'b0);
      repeat (2) @(posedge clk);
    end
    wr(`IVM_OFS_PER_EN, 32'h1ff);
    bus_error <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp_irq(1'b0, 11, 2'h0);
    @(posedge clk);
    bus_error <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      slow <= $urandom;
      wr(`IVM_OFS_SOFT, 32'h1 << i);
      #1 cmp_irq(1'b1, (i == 3) ? 3 : 17 - i, i);
      n = 0;
      while (irq_req === 1'b1 && n < 12) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk);
      rd(`IVM_OFS_SOFT, d);
      cmp32(d, 32'h0);
    end
    wr(`IVM_OFS_TMR_EN, 32'h7fff);
    wr(`IVM_OFS_PER_EN, 32'h3ff);
    wr(`IVM_OFS_PRIO0, 32'h3ff);
    wr(`IVM_OFS_PRIO1, 32'h3fff);
    foreach (vl[i]) set_src(vl[i], 1'b1);
    repeat (3) @(posedge clk);
    rd(`IVM_OFS_PEND, d);
    cmp32(d, 32'h0e1c0ff4);
    rd(`IVM_OFS_ACTIVE, d);
    cmp32(d, 32'h00002062);
    #1 cmp_irq(1'b1, 2, 2'h3);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule // ivm_vector_map_tb
